//--- crph_cfg.svh
`ifndef CRPH_CFG_SVH
`define CRPH_CFG_SVH
// APB register byte offsets
`define CRPH_OFF_CTRL 12'h000
`define CRPH_OFF_STAT 12'h004
`define CRPH_OFF_MASK 12'h008
`define CRPH_OFF_PRIM 12'h00C
`define CRPH_OFF_PC 12'h010
`define CRPH_OFF_IADDR 12'h014
`define CRPH_OFF_ACT 12'h018
// Primitive field positions
`define CRPH_BIT_CA 15
`define CRPH_BIT_PIA 14
`define CRPH_BIT_DIR 13
// Busy pattern with flag bit 14 masked off
`define CRPH_BUSY_MASK 16'hBFFF
`define CRPH_BUSY_VAL 16'hA400
// Null primitive: bits 13..9 equal 00100, bits 7..2 zero
`define CRPH_NULL_MASK 16'h3EFC
`define CRPH_NULL_VAL 16'h0800
// Status bit positions
`define CRPH_ST_BUSY 0
`define CRPH_ST_PROTO 1
`define CRPH_ST_DONE 2
`define CRPH_ST_BKPT 3
`define CRPH_ST_W 4
// Reset values
`define CRPH_RST_MASK 4'h0
`endif

//--- crph_pkg.sv
package crph_pkg;
  typedef enum logic [2:0] {
    CRPH_IDLE, CRPH_RD_REQ, CRPH_RD_WAIT, CRPH_PC_REQ, CRPH_PC_WAIT, CRPH_SERVE
  } crph_st_t;
endpackage

//--- crph_top.sv
// Notes on behaviour
// - A primitive is a 16-bit response word whose top three bits are flags and lower 13 bits are fields.
// - With come-again set on a null primitive, the service is done and the response register is read again.
// - With pass-address set, the program counter is written to the instruction address register first.
// - The pass-address flag is honoured in every defined primitive.
// - Undefined primitives raise a protocol exception, after passing the address if flagged.
// - A clear direction flag means a processor write, a set one a processor read.
// - Busy is bit 15, pass flag at 14, bits 13 and 10 one, the rest zero, for both categories.
// - On busy, pending interrupts are serviced pre-instruction and the instruction is restarted.
// - Busy from a breakpoint-started instruction with an interrupt pending repeats the breakpoint cycle.
`include "crph_cfg.svh"
module crph_top
  import crph_pkg::*;
#(
  parameter int AW = 32
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Interface register port toward coprocessor
  output logic CIR_REQ,
  output logic CIR_WRITE,
  output logic CIR_IADDR_SEL,
  output logic [AW-1:0] CIR_WDATA,
  input wire logic CIR_ACK,
  input wire logic [15:0] CIR_RDATA,
  // Processor status inputs
  input wire logic IRQ_PENDING,
  input wire logic BKPT_START,
  // Actions to the processor
  output logic SERVICE_REQ,
  output logic XFER_READ,
  output logic RESTART_INSTR,
  output logic REPEAT_BKPT,
  output logic PROTO_EXC,
  output logic PRE_INSTR_INT,
  // Interrupt
  output logic IRQ
);

  typedef struct packed {
    crph_st_t st;
    logic [15:0] prim;
    logic [AW-1:0] pc;
    logic [AW-1:0] iaddr;
    logic [3:0] stat;
    logic [3:0] mask;
    logic bkpt;
    logic [31:0] rdata;
    logic svc;
    logic xrd;
    logic rst_i;
    logic rep_b;
    logic pexc;
    logic pint;
    logic req;
    logic wr;
    logic isel;
    logic [AW-1:0] wdata;
  } crph_s_t;

  crph_s_t s_q;
  crph_s_t s_d;

  function automatic logic is_busy(input logic [15:0] p);
    return (p & `CRPH_BUSY_MASK) == `CRPH_BUSY_VAL;
  endfunction

  function automatic logic is_null(input logic [15:0] p);
    return (p & `CRPH_NULL_MASK) == `CRPH_NULL_VAL;
  endfunction

  function automatic logic [31:0] reg_word(input logic [11:0] a, input crph_s_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      `CRPH_OFF_CTRL: begin
        w = {31'h0, s.st != CRPH_IDLE};
      end
      `CRPH_OFF_STAT: begin
        w = {28'h0, s.stat};
      end
      `CRPH_OFF_MASK: begin
        w = {28'h0, s.mask};
      end
      `CRPH_OFF_PRIM: begin
        w = {16'h0, s.prim};
      end
      `CRPH_OFF_PC: begin
        w = 32'(s.pc);
      end
      `CRPH_OFF_IADDR: begin
        w = 32'(s.iaddr);
      end
      `CRPH_OFF_ACT: begin
        w = {31'h0, s.xrd};
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // Out of range or not word aligned
  function automatic logic addr_bad(input logic [11:0] a);
    return (a > `CRPH_OFF_ACT) || (a[1:0] != 2'h0);
  endfunction

  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic [3:0] ev;

  assign apb_acc = PSEL && PENABLE;
  assign apb_wr = apb_acc && PWRITE;
  assign apb_rd = apb_acc && !PWRITE;

  always_comb begin
    s_d = s_q;
    ev = 4'h0;
    s_d.svc = 1'b0;
    s_d.rst_i = 1'b0;
    s_d.rep_b = 1'b0;
    s_d.pexc = 1'b0;
    s_d.pint = 1'b0;
    s_d.rdata = 32'h0000_0000;
    // Register writes
    if (apb_wr) begin
      unique case (PADDR)
        `CRPH_OFF_CTRL: begin
          if (PWDATA[0] && s_q.st == CRPH_IDLE) begin
            s_d.st = CRPH_RD_REQ;
            s_d.bkpt = BKPT_START;
          end
        end
        `CRPH_OFF_MASK: s_d.mask = PWDATA[3:0];
        `CRPH_OFF_PC: s_d.pc = PWDATA[AW-1:0];
        default: ;
      endcase
    end
    unique case (s_q.st)
      CRPH_IDLE: ;
      CRPH_RD_REQ: begin
        // Response register read, 16-bit word
        s_d.req = 1'b1;
        s_d.wr = 1'b0;
        s_d.isel = 1'b0;
        s_d.st = CRPH_RD_WAIT;
      end
      CRPH_RD_WAIT: begin
        if (CIR_ACK) begin
          s_d.req = 1'b0;
          s_d.prim = CIR_RDATA;
          s_d.xrd = CIR_RDATA[`CRPH_BIT_DIR];
          // Address goes out first for any primitive, even an undefined one
          if (CIR_RDATA[`CRPH_BIT_PIA]) begin
            s_d.st = CRPH_PC_REQ;
          end else begin
            s_d.st = CRPH_SERVE;
          end
        end
      end
      CRPH_PC_REQ: begin
        s_d.req = 1'b1;
        s_d.wr = 1'b1;
        s_d.isel = 1'b1;
        s_d.wdata = s_q.pc;
        s_d.iaddr = s_q.pc;
        s_d.st = CRPH_PC_WAIT;
      end
      CRPH_PC_WAIT: begin
        if (CIR_ACK) begin
          s_d.req = 1'b0;
          s_d.wr = 1'b0;
          s_d.isel = 1'b0;
          s_d.st = CRPH_SERVE;
        end
      end
      CRPH_SERVE: begin
        if (is_busy(s_q.prim)) begin
          // Busy wins over come-again; both categories decode it alike
          ev[`CRPH_ST_BUSY] = 1'b1;
          s_d.pint = IRQ_PENDING;
          s_d.rst_i = 1'b1;
          s_d.rep_b = s_q.bkpt && IRQ_PENDING;
          if (s_q.bkpt && IRQ_PENDING) begin
            ev[`CRPH_ST_BKPT] = 1'b1;
          end
          s_d.st = CRPH_IDLE;
        end else if (!is_null(s_q.prim)) begin
          // Only busy and null are known here; the rest go to the handler
          ev[`CRPH_ST_PROTO] = 1'b1;
          s_d.pexc = 1'b1;
          s_d.st = CRPH_IDLE;
        end else begin
          s_d.svc = 1'b1;
          if (s_q.prim[`CRPH_BIT_CA]) begin
            s_d.st = CRPH_RD_REQ;
          end else begin
            ev[`CRPH_ST_DONE] = 1'b1;
            s_d.st = CRPH_IDLE;
          end
        end
      end
      default: s_d.st = CRPH_IDLE;
    endcase
    // Read word captured in the setup cycle so the bus data leaves a flop
    if (PSEL && !PENABLE && !PWRITE) begin
      s_d.rdata = reg_word(PADDR, s_q);
    end
    // Status read clears only the captured bits; later events survive, set wins
    if (apb_rd && PADDR == `CRPH_OFF_STAT) begin
      s_d.stat = s_q.stat & ~s_q.rdata[3:0];
    end
    s_d.stat = s_d.stat | ev;
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      s_q <= '0;
      s_q.st <= CRPH_IDLE;
      s_q.mask <= `CRPH_RST_MASK;
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave; the word stands only in the access cycle
  assign PRDATA = s_q.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = apb_acc && addr_bad(PADDR);
  assign CIR_REQ = s_q.req;
  assign CIR_WRITE = s_q.wr;
  assign CIR_IADDR_SEL = s_q.isel;
  assign CIR_WDATA = s_q.wdata;
  assign SERVICE_REQ = s_q.svc;
  assign XFER_READ = s_q.xrd;
  assign RESTART_INSTR = s_q.rst_i;
  assign REPEAT_BKPT = s_q.rep_b;
  assign PROTO_EXC = s_q.pexc;
  assign PRE_INSTR_INT = s_q.pint;
  assign IRQ = |(s_q.stat & s_q.mask);

endmodule // crph_top

//--- crph_sva.sv
`include "crph_cfg.svh"
module crph_sva (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Watched ports
  input wire logic CIR_REQ,
  input wire logic CIR_WRITE,
  input wire logic CIR_IADDR_SEL,
  input wire logic CIR_ACK,
  input wire logic [15:0] CIR_RDATA,
  input wire logic IRQ_PENDING,
  input wire logic XFER_READ,
  input wire logic RESTART_INSTR,
  input wire logic REPEAT_BKPT,
  input wire logic PROTO_EXC,
  input wire logic PRE_INSTR_INT
);
  wire rd = CIR_REQ && CIR_ACK && !CIR_WRITE;
  wire bsy = (CIR_RDATA & `CRPH_BUSY_MASK) == `CRPH_BUSY_VAL;
  wire nul = (CIR_RDATA & `CRPH_NULL_MASK) == `CRPH_NULL_VAL;
  wire pia = rd && CIR_RDATA[14];
  wire dir_bit = CIR_RDATA[13];
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  property p_ca; rd && nul && CIR_RDATA[15] && !CIR_RDATA[14] |-> ##[2:8] CIR_REQ && !CIR_WRITE;
  endproperty
  a_ca: assert property (p_ca) else $error("no reread");
  property p_pia; pia |-> ##[1:4] CIR_REQ && CIR_WRITE && CIR_IADDR_SEL; endproperty
  a_pia: assert property (p_pia) else $error("address not passed");
  property p_first; pia |=> !(PROTO_EXC || RESTART_INSTR) [*3]; endproperty
  a_first: assert property (p_first) else $error("served before address");
  property p_undef; rd && !bsy && !nul && !CIR_RDATA[14] |-> ##[1:4] PROTO_EXC; endproperty
  a_undef: assert property (p_undef) else $error("no exception");
  property p_busy; rd && bsy && !CIR_RDATA[14] |-> ##[1:4] RESTART_INSTR; endproperty
  a_busy: assert property (p_busy) else $error("no restart");
  property p_pre;
    (RESTART_INSTR || PRE_INSTR_INT) |-> RESTART_INSTR && PRE_INSTR_INT == $past(IRQ_PENDING);
  endproperty
  a_pre: assert property (p_pre) else $error("interrupt service wrong");
  property p_bkpt; REPEAT_BKPT |-> PRE_INSTR_INT && RESTART_INSTR; endproperty
  a_bkpt: assert property (p_bkpt) else $error("bad breakpoint repeat");
  property p_dir; rd |=> XFER_READ == $past(dir_bit); endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  c_bkpt: cover property (REPEAT_BKPT);
  c_exc: cover property (PROTO_EXC);
  c_ca: cover property (rd && nul && CIR_RDATA[15]);
endmodule // crph_sva
bind crph_top crph_sva crph_sva_inst (.*);

//--- crph_cop_model.sv
module crph_cop_model (
  // Clock, reset, requests
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic wr,
  input wire logic [31:0] wdata,
  // Scenario controls
  input wire logic [15:0] prim,
  input wire logic [3:0] dly,
  // Answers
  output logic ack,
  output logic [15:0] rdata,
  output logic [31:0] iaddr
);
  logic [3:0] cnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      cnt <= 4'h0;
      rdata <= 16'h0000;
      iaddr <= 32'h0;
    end else begin
      ack <= 1'b0;
      // Idle word toggles so a late sample fails
      rdata <= ~rdata;
      if (req && !ack && cnt < dly) begin
        cnt <= cnt + 4'h1;
      end else if (req && !ack) begin
        ack <= 1'b1;
        cnt <= 4'h0;
        rdata <= prim;
        if (wr) iaddr <= wdata;
      end
    end
  end
endmodule // crph_cop_model

//--- crph_top_tb.sv
`include "crph_cfg.svh"
module crph_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_SYS = 0, RST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic IRQ_PENDING = 0, BKPT_START = 0, err;
  logic PREADY, PSLVERR, CIR_REQ, CIR_WRITE, CIR_IADDR_SEL, CIR_ACK, SERVICE_REQ, XFER_READ;
  logic RESTART_INSTR, REPEAT_BKPT, PROTO_EXC, PRE_INSTR_INT, IRQ;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, CIR_WDATA, iaddr, r;
  logic [15:0] CIR_RDATA, prim_now, prim = 16'h0000;
  logic [3:0] dly = 4'h0;
  int num_errors = 0, check_count = 0, acks = 0, a;
  int svcs = 0, rsts = 0, pints = 0, reps = 0, excs = 0;
  crph_top crph_top_inst (.*);
  crph_cop_model crph_cop_model_inst (.clk(CLK_SYS), .rst(RST), .req(CIR_REQ), .wr(CIR_WRITE),
    .wdata(CIR_WDATA), .prim(prim_now), .dly(dly), .ack(CIR_ACK), .rdata(CIR_RDATA),
    .iaddr(iaddr));
  initial forever #2 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) if (CIR_ACK === 1'b1) acks <= acks + 1;
  // Come-again null is followed by a closing null
  assign prim_now = (prim == 16'h8800 && acks != a) ? 16'h0800 : prim;
  // Pulse outputs counted so every action is judged
  always @(posedge CLK_SYS) begin
    if (SERVICE_REQ === 1'b1) svcs <= svcs + 1;
    if (RESTART_INSTR === 1'b1) rsts <= rsts + 1;
    if (PRE_INSTR_INT === 1'b1) pints <= pints + 1;
    if (REPEAT_BKPT === 1'b1) reps <= reps + 1;
    if (PROTO_EXC === 1'b1) excs <= excs + 1;
  end
  task automatic chk(input string n, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    r = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // Polls the active flag so no start lands on a busy dialogue
  task automatic run(input logic [15:0] p, input logic [3:0] d, m, st);
    prim <= p;
    dly <= d;
    apb(1'b1, `CRPH_OFF_MASK, {28'h0, m});
    apb(1'b1, `CRPH_OFF_CTRL, 32'h1);
    repeat (20) begin
      apb(1'b0, `CRPH_OFF_CTRL, 32'h0);
      if (r[0] === 1'b0) break;
    end
    chk("idle", r[0], 1'b0);
    chk("irq", IRQ, |(st & m));
    apb(1'b0, `CRPH_OFF_STAT, 32'h0);
    chk("status", r[3:0], st);
    @(posedge CLK_SYS);
    chk("irq clear", IRQ, 1'b0);
  endtask
  task automatic t_busy_bkpt;
    IRQ_PENDING <= 1'b1;
    BKPT_START <= 1'b1;
    run(16'hA400, 4'h0, 4'hF, 4'h9);
    chk("restart", rsts, 1);
    chk("pre-instr int", pints, 1);
    chk("bkpt repeat", reps, 1);
    IRQ_PENDING <= 1'b0;
    BKPT_START <= 1'b0;
  endtask
  task automatic t_busy_pass;
    run(16'hE400, 4'h5, 4'h2, 4'h1);
    chk("iaddr", iaddr, 32'h00001234);
    chk("restart", rsts, 2);
    chk("no int", pints, 1);
    chk("no repeat", reps, 1);
  endtask
  task automatic t_undef_pass;
    apb(1'b1, `CRPH_OFF_PC, 32'h00005678);
    run(16'h5555, 4'h2, 4'hF, 4'h2);
    chk("iaddr new", iaddr, 32'h00005678);
    apb(1'b0, `CRPH_OFF_IADDR, 32'h0);
    chk("iaddr reg", r, 32'h00005678);
    chk("exc", excs, 1);
  endtask
  task automatic t_undef_dir;
    run(16'h2000, 4'h1, 4'hF, 4'h2);
    chk("dir", XFER_READ, 1'b1);
    apb(1'b0, `CRPH_OFF_ACT, 32'h0);
    chk("dir reg", r, 32'h1);
    chk("exc", excs, 2);
  endtask
  task automatic t_come_again;
    a = acks;
    run(16'h8800, 4'h3, 4'h4, 4'h4);
    chk("reads", acks - a, 2);
    chk("services", svcs, 2);
    chk("dir clear", XFER_READ, 1'b0);
  endtask
  task automatic t_unmapped;
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", r, 32'h0);
  endtask
  initial begin
    RST = 1'b1;
    repeat (20) @(posedge CLK_SYS);
    RST <= 1'b0;
    apb(1'b1, `CRPH_OFF_PC, 32'h00001234);
    t_busy_bkpt;
    t_busy_pass;
    t_undef_pass;
    t_undef_dir;
    t_come_again;
    t_unmapped;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    num_errors++;
    report_and_stop;
  end
endmodule // crph_top_tb
